// >>> pkg/frt_defs.svh
// register offsets, field positions, reset values and counts of the free-running timer
`ifndef FRT_DEFS_SVH
`define FRT_DEFS_SVH

// byte offsets on the register port
`define FRT_ADDR_CNT_HI      8'h00
`define FRT_ADDR_CNT_LO      8'h01
`define FRT_ADDR_MIRROR_HI   8'h02
`define FRT_ADDR_MIRROR_LO   8'h03
`define FRT_ADDR_STATUS      8'h04
`define FRT_ADDR_CTRL_ONE    8'h05
`define FRT_ADDR_CTRL_TWO    8'h06

// field positions
`define FRT_SR_OVF_BIT       5
`define FRT_CR1_OVIE_BIT     5
`define FRT_CR2_CS_LSB       0
`define FRT_CR2_CS_MSB       1
`define FRT_CR2_EDGE_BIT     2

// clock select encodings
`define FRT_CS_DIV2          2'h0
`define FRT_CS_DIV4          2'h1
`define FRT_CS_DIV8          2'h2
`define FRT_CS_EXT           2'h3

// prescaler terminal counts (divide by n ends at n-1)
`define FRT_PRE_END_DIV2     3'h1
`define FRT_PRE_END_DIV4     3'h3
`define FRT_PRE_END_DIV8     3'h7

// reset and reload values
`define FRT_CNT_RELOAD       16'hfffc
`define FRT_CNT_TOP          16'hffff
`define FRT_CNT_ONE          16'h0001
`define FRT_CTRL_RESET       8'h00
`define FRT_RD_NONE          8'h00

`endif

// >>> pkg/frt_pkg.sv
// types shared by the free-running timer counter files
package frt_pkg;

  typedef logic [1:0] frt_clksel_t;
  typedef logic [7:0] frt_byte_t;
  typedef logic [15:0] frt_count_t;

  // state of the buffered 16-bit read sequence
  typedef enum logic {
    RDSEQ_IDLE,
    RDSEQ_BUFFERED
  } frt_rdseq_t;

endpackage

// >>> hw/frt_prescaler.sv
// prescaler that divides the system clock by 2, 4 or 8 into a one-cycle tick
`timescale 1ns/1ps
`include "frt_defs.svh"

module frt_prescaler
  import frt_pkg::*;
(
  input  wire logic        clk_sys,  // system clock
  input  wire logic        arst_n,   // asynchronous reset, active low
  input  wire logic        run,      // count enable, low freezes the division
  input  wire logic        restart,  // start a fresh division period
  input  wire frt_clksel_t div_sel,  // division select
  output logic             tick      // one-cycle timer clock enable
);

  logic [2:0] div_cnt_reg;
  logic [2:0] div_cnt_next;
  logic [2:0] div_end;
  logic       at_end;

  assign div_end = (div_sel == `FRT_CS_DIV2) ? `FRT_PRE_END_DIV2 :
                   (div_sel == `FRT_CS_DIV4) ? `FRT_PRE_END_DIV4 :
                                               `FRT_PRE_END_DIV8;  // [RULE2]
  // masking with the end value keeps a select change from stalling a full wrap
  assign at_end = ((div_cnt_reg & div_end) == div_end);
  assign tick = run & ~restart & at_end;  // [RULE1]
  assign div_cnt_next = restart ? 3'h0 :
                        ~run    ? div_cnt_reg :
                        at_end  ? 3'h0 :
                                  div_cnt_reg + 3'h1;  // [RULE21]

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_reg <= 3'h0;  // [RULE20]
    end else begin
      div_cnt_reg <= div_cnt_next;
    end
  end

endmodule

// >>> hw/frt_top.sv
// 16-bit free-running timer counter with buffered byte reads and overflow flag
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "frt_defs.svh"

// Behaviour
// RULE1 - sixteen-bit up-counter runs freely, one step per timer tick
// RULE2 - prescaler divides system clock by 2, 4 or 8 per clock select
// RULE3 - writing either low byte forces the counter to fffc
// RULE4 - reset leaves the counter at fffc in every operating mode
// RULE5 - count readable as high/low bytes, mirrored by a second pair
// RULE6 - mirror low-byte read never clears the overflow flag
// RULE7 - high byte read first latches the low byte into a buffer
// RULE8 - buffered low byte stays frozen through repeated high reads until low read
// RULE9 - lone low-byte read after a finished sequence returns live low byte
// RULE10 - rollover from ffff to 0000 sets the overflow flag
// RULE11 - interrupt only while enable set and global mask clear, else pending
// RULE12 - flag clears after status read while set, then main low access
// RULE13 - wait mode leaves the counter running unchanged
// RULE14 - halt stops the counter; resumes from held count or from reset
// RULE15 - clock select both ones picks the external clock pin
// RULE16 - edge select picks rising or falling external transitions
// RULE17 - external events are synchronised to the system clock
// RULE18 - external source leaves four system clocks between active edges
// RULE19 - an unbonded timer input always reads as one
// RULE20 - instances start in step after reset and stay in step
// RULE21 - a reload restarts the prescaler for a full first period
module frt_top
  import frt_pkg::*;
#(
  parameter bit EXT_PIN_BONDED = 1'b1  // external clock pin present on the package
)
(
  input  wire logic        clk_sys,          // system clock, 20 MHz
  input  wire logic        arst_n,           // asynchronous reset, active low
  input  wire logic [7:0]  addr,             // register byte address
  input  wire logic [7:0]  wr_data,          // register write data
  input  wire logic        wr_stb,           // register write strobe
  input  wire logic        rd_stb,           // register read strobe
  output logic      [7:0]  rd_data,          // read data, cycle after rd_stb
  input  wire logic        global_irq_mask,  // processor global interrupt mask
  input  wire logic        halt_mode,        // processor halt, freezes the counter
  input  wire logic        ext_clock_pin,    // external timer clock pin
  output logic             overflow_irq,     // overflow interrupt request
  output logic      [15:0] count_value       // live counter for compare and capture users
);

  // state
  frt_count_t  counter_reg;
  frt_count_t  counter_next;
  frt_byte_t   lo_buf_reg;
  frt_byte_t   lo_buf_next;
  frt_rdseq_t  rdseq_reg;
  frt_rdseq_t  rdseq_next;
  logic        overflow_flag_reg;
  logic        overflow_flag_next;
  logic        clear_armed_reg;
  logic        clear_armed_next;
  logic        overflow_irq_enable_reg;
  logic        overflow_irq_enable_next;
  frt_clksel_t clock_select_field_reg;
  frt_clksel_t clock_select_field_next;
  logic        ext_clock_edge_select_reg;
  logic        ext_clock_edge_select_next;
  frt_byte_t   rd_data_reg;
  frt_byte_t   rd_data_next;
  logic        overflow_irq_reg;
  logic        overflow_irq_next;

  // external clock synchroniser and filtered level
  logic        ext_sync_a_reg;
  logic        ext_sync_b_reg;
  logic        ext_sync_c_reg;
  logic        ext_level_reg;
  logic        ext_level_next;

  // decode
  logic        sel_cnt_hi;
  logic        sel_cnt_lo;
  logic        sel_mirror_hi;
  logic        sel_mirror_lo;
  logic        sel_status;
  logic        sel_ctrl_one;
  logic        sel_ctrl_two;
  logic        hi_read;
  logic        lo_read;
  logic        main_lo_access;
  logic        status_read;
  logic        reload;
  logic        wr_ctrl_one;
  logic        wr_ctrl_two;

  assign sel_cnt_hi    = (addr == `FRT_ADDR_CNT_HI);
  assign sel_cnt_lo    = (addr == `FRT_ADDR_CNT_LO);
  assign sel_mirror_hi = (addr == `FRT_ADDR_MIRROR_HI);
  assign sel_mirror_lo = (addr == `FRT_ADDR_MIRROR_LO);
  assign sel_status    = (addr == `FRT_ADDR_STATUS);
  assign sel_ctrl_one  = (addr == `FRT_ADDR_CTRL_ONE);
  assign sel_ctrl_two  = (addr == `FRT_ADDR_CTRL_TWO);

  // both pairs share one sequence and one buffer, so mixing them still pairs up
  assign hi_read        = rd_stb & (sel_cnt_hi | sel_mirror_hi);  // [RULE5]
  assign lo_read        = rd_stb & (sel_cnt_lo | sel_mirror_lo);  // [RULE5]
  // only the main low byte takes part in clearing the flag
  assign main_lo_access = (rd_stb | wr_stb) & sel_cnt_lo;  // [RULE6] [RULE12]
  assign status_read    = rd_stb & sel_status;
  assign reload         = wr_stb & (sel_cnt_lo | sel_mirror_lo);  // [RULE3]
  assign wr_ctrl_one    = wr_stb & sel_ctrl_one;
  assign wr_ctrl_two    = wr_stb & sel_ctrl_two;

  // control registers
  assign overflow_irq_enable_next = wr_ctrl_one ? wr_data[`FRT_CR1_OVIE_BIT] :
                                                  overflow_irq_enable_reg;
  assign clock_select_field_next  = wr_ctrl_two ?
                                    wr_data[`FRT_CR2_CS_MSB:`FRT_CR2_CS_LSB] :
                                    clock_select_field_reg;
  assign ext_clock_edge_select_next = wr_ctrl_two ? wr_data[`FRT_CR2_EDGE_BIT] :
                                                    ext_clock_edge_select_reg;

  // external clock
  logic        ext_pin_level;
  logic        ext_stable;
  logic        ext_change;
  logic        ext_tick;
  logic        ext_selected;

  // a missing pin floats to a fixed high level and so never produces an edge
  assign ext_pin_level = EXT_PIN_BONDED ? ext_clock_pin : 1'b1;  // [RULE19]
  assign ext_stable    = (ext_sync_b_reg == ext_sync_c_reg);  // [RULE17]
  assign ext_change    = ext_stable & (ext_sync_b_reg != ext_level_reg);
  // new level equal to the edge select means rising (1) or falling (0)
  assign ext_tick      = ext_change & (ext_sync_b_reg == ext_clock_edge_select_reg);  // [RULE16]
  assign ext_level_next = ext_change ? ext_sync_b_reg : ext_level_reg;
  assign ext_selected  = (clock_select_field_reg == `FRT_CS_EXT);  // [RULE15]

  // the synchroniser costs three clocks of latency; edges closer than four
  // system clocks apart may merge and lose a count
  // [RULE18]

  // prescaler
  logic        pre_tick;
  logic        pre_run;

  // wait mode has no input here: only halt stops the counter
  assign pre_run = ~halt_mode & ~ext_selected;  // [RULE13] [RULE14]

  frt_prescaler u_prescaler (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .run     (pre_run),
    .restart (reload),
    .div_sel (clock_select_field_reg),
    .tick    (pre_tick)
  );

  // counter
  logic        cnt_advance;
  logic        overflow_event;

  assign cnt_advance    = ~halt_mode & (ext_selected ? ext_tick : pre_tick);  // [RULE14] [RULE1]
  assign overflow_event = cnt_advance & ~reload & (counter_reg == `FRT_CNT_TOP);  // [RULE10]
  assign counter_next   = reload      ? `FRT_CNT_RELOAD :
                          cnt_advance ? counter_reg + `FRT_CNT_ONE :
                                        counter_reg;  // [RULE3] [RULE1]

  // overflow flag
  logic        flag_clear;

  assign flag_clear = clear_armed_reg & main_lo_access;  // [RULE12]
  // a rollover in the clearing cycle keeps the flag set
  assign overflow_flag_next = overflow_event | (overflow_flag_reg & ~flag_clear);  // [RULE10]
  assign clear_armed_next   = (status_read & overflow_flag_reg) ? 1'b1 :
                              flag_clear                      ? 1'b0 :
                                                                clear_armed_reg;  // [RULE12]
  // the request stays pending in the flag while enable or mask blocks it
  assign overflow_irq_next  = overflow_flag_reg & overflow_irq_enable_reg &
                              ~global_irq_mask;  // [RULE11]

  // read sequence
  logic        seq_buffered;

  assign seq_buffered = (rdseq_reg == RDSEQ_BUFFERED);

  always_comb begin
    rdseq_next  = rdseq_reg;
    lo_buf_next = lo_buf_reg;
    case (rdseq_reg)
      RDSEQ_IDLE: begin
        if (hi_read) begin
          lo_buf_next = counter_reg[7:0];  // [RULE7]
          rdseq_next  = RDSEQ_BUFFERED;
        end
      end
      RDSEQ_BUFFERED: begin
        // further high reads leave the buffer untouched
        if (lo_read) begin
          rdseq_next = RDSEQ_IDLE;  // [RULE8]
        end
      end
      default: begin
        rdseq_next = RDSEQ_IDLE;
      end
    endcase
  end

  // read data
  frt_byte_t   lo_read_value;
  frt_byte_t   status_value;
  frt_byte_t   ctrl_one_value;
  frt_byte_t   ctrl_two_value;
  frt_byte_t   read_mux;

  assign lo_read_value  = seq_buffered ? lo_buf_reg : counter_reg[7:0];  // [RULE8] [RULE9]
  assign status_value   = 8'(overflow_flag_reg) << `FRT_SR_OVF_BIT;
  assign ctrl_one_value = 8'(overflow_irq_enable_reg) << `FRT_CR1_OVIE_BIT;
  assign ctrl_two_value = (8'(clock_select_field_reg) << `FRT_CR2_CS_LSB) |
                          (8'(ext_clock_edge_select_reg) << `FRT_CR2_EDGE_BIT);

  assign read_mux = (sel_cnt_hi | sel_mirror_hi) ? counter_reg[15:8] :  // [RULE5]
                    (sel_cnt_lo | sel_mirror_lo) ? lo_read_value :
                    sel_status                   ? status_value :
                    sel_ctrl_one                 ? ctrl_one_value :
                    sel_ctrl_two                 ? ctrl_two_value :
                                                   `FRT_RD_NONE;
  // data stand for one cycle only, zero otherwise
  assign rd_data_next = rd_stb ? read_mux : `FRT_RD_NONE;

  // flip-flops
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      counter_reg <= `FRT_CNT_RELOAD;  // [RULE4] [RULE20]
    end else begin
      counter_reg <= counter_next;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdseq_reg  <= RDSEQ_IDLE;
      lo_buf_reg <= 8'h00;
    end else begin
      rdseq_reg  <= rdseq_next;
      lo_buf_reg <= lo_buf_next;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      overflow_flag_reg <= 1'b0;
      clear_armed_reg   <= 1'b0;
      overflow_irq_reg  <= 1'b0;
    end else begin
      overflow_flag_reg <= overflow_flag_next;
      clear_armed_reg   <= clear_armed_next;
      overflow_irq_reg  <= overflow_irq_next;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      overflow_irq_enable_reg   <= 1'b0;
      clock_select_field_reg    <= `FRT_CS_DIV2;
      ext_clock_edge_select_reg <= 1'b0;
    end else begin
      overflow_irq_enable_reg   <= overflow_irq_enable_next;
      clock_select_field_reg    <= clock_select_field_next;
      ext_clock_edge_select_reg <= ext_clock_edge_select_next;
    end
  end

  // the idle level is high so a pin that starts high gives no false edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ext_sync_a_reg <= 1'b1;
      ext_sync_b_reg <= 1'b1;
      ext_sync_c_reg <= 1'b1;
      ext_level_reg  <= 1'b1;
    end else begin
      ext_sync_a_reg <= ext_pin_level;  // [RULE17]
      ext_sync_b_reg <= ext_sync_a_reg;
      ext_sync_c_reg <= ext_sync_b_reg;
      ext_level_reg  <= ext_level_next;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_reg <= `FRT_RD_NONE;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data      = rd_data_reg;
  assign overflow_irq = overflow_irq_reg;
  assign count_value  = counter_reg;

endmodule

// >>> tb/frt_top_monitor.sv
// concurrent checks on the ports of the free-running timer counter
`timescale 1ns/1ps
`include "frt_defs.svh"

module frt_top_monitor
  import frt_pkg::*;
#(
  parameter bit EXT_PIN_BONDED = 1'b1  // pin present
)
(
  input wire logic        clk_sys,          // clock
  input wire logic        arst_n,           // reset
  input wire logic [7:0]  addr,             // address
  input wire logic [7:0]  wr_data,          // write data
  input wire logic        wr_stb,           // write strobe
  input wire logic        rd_stb,           // read strobe
  input wire logic [7:0]  rd_data,          // read data
  input wire logic        global_irq_mask,  // global mask
  input wire logic        halt_mode,        // halt
  input wire logic        ext_clock_pin,    // ext clock
  input wire logic        overflow_irq,     // irq
  input wire logic [15:0] count_value       // counter
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  wire logic hi_rd = rd_stb && (addr == `FRT_ADDR_CNT_HI || addr == `FRT_ADDR_MIRROR_HI);
  wire logic lo_rd = rd_stb && (addr == `FRT_ADDR_CNT_LO || addr == `FRT_ADDR_MIRROR_LO);
  wire logic lo_wr = wr_stb && (addr == `FRT_ADDR_CNT_LO || addr == `FRT_ADDR_MIRROR_LO);
  wire logic en_off = wr_stb && addr == `FRT_ADDR_CTRL_ONE && !wr_data[`FRT_CR1_OVIE_BIT];
  wire logic [7:0] cnt_hi_byte = count_value[15:8];
  wire logic [7:0] cnt_lo_byte = count_value[7:0];

  // shadow of the shared read buffer; only the first high read of a sequence latches
  logic      seq_pend_reg;
  frt_byte_t seq_buf_reg;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      seq_pend_reg <= 1'b0;
      seq_buf_reg  <= 8'h00;
    end else if (hi_rd && !seq_pend_reg) begin
      seq_pend_reg <= 1'b1;
      seq_buf_reg  <= count_value[7:0];
    end else if (lo_rd) begin
      seq_pend_reg <= 1'b0;
    end
  end

  property p_reload; lo_wr |=> count_value == `FRT_CNT_RELOAD; endproperty
  a_reload: assert property (p_reload) else $error("reload value wrong");
  property p_step;
    !$stable(count_value) |->
      count_value == $past(count_value) + `FRT_CNT_ONE || count_value == `FRT_CNT_RELOAD;
  endproperty
  a_step: assert property (p_step) else $error("counter jumped");
  // three halted cycles, though halt gates the counter advance in the same cycle it is sampled
  property p_halt; halt_mode[*3] ##0 !lo_wr |=> $stable(count_value); endproperty
  a_halt: assert property (p_halt) else $error("counter moved in halt");
  property p_hi; hi_rd |=> rd_data == $past(cnt_hi_byte); endproperty
  a_hi: assert property (p_hi) else $error("high byte wrong");
  property p_lo_buf; lo_rd && seq_pend_reg |=> rd_data == $past(seq_buf_reg); endproperty
  a_lo_buf: assert property (p_lo_buf) else $error("buffered low byte wrong");
  property p_lo_live; lo_rd && !seq_pend_reg |=> rd_data == $past(cnt_lo_byte); endproperty
  a_lo_live: assert property (p_lo_live) else $error("live low byte wrong");
  property p_rd_idle; !rd_stb |=> rd_data == `FRT_RD_NONE; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_mask; global_irq_mask |=> !overflow_irq; endproperty
  a_mask: assert property (p_mask) else $error("irq while masked");
  property p_en_off; en_off |=> ##1 !overflow_irq; endproperty
  a_en_off: assert property (p_en_off) else $error("irq while disabled");

  c_reload: cover property (lo_wr);
  c_irq: cover property ($rose(overflow_irq));
  c_buf: cover property (lo_rd && seq_pend_reg);
endmodule

bind frt_top frt_top_monitor #(.EXT_PIN_BONDED(EXT_PIN_BONDED)) u_frt_top_monitor (
  .clk_sys(clk_sys), .arst_n(arst_n), .addr(addr), .wr_data(wr_data),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
  .global_irq_mask(global_irq_mask), .halt_mode(halt_mode),
  .ext_clock_pin(ext_clock_pin), .overflow_irq(overflow_irq), .count_value(count_value)
);

// >>> tb/tb_top.sv
// self-checking bench for the free-running timer counter
`timescale 1ns/1ps
`include "frt_defs.svh"

module tb_top
  import frt_pkg::*;
;
  localparam frt_byte_t OVF_B = 8'h01 << `FRT_SR_OVF_BIT;
  localparam frt_byte_t EN_B  = 8'h01 << `FRT_CR1_OVIE_BIT;

  logic       clk_sys;
  logic       arst_n;
  frt_byte_t  addr;
  frt_byte_t  wr_data;
  logic       wr_stb;
  logic       rd_stb;
  frt_byte_t  rd_data;
  logic       global_irq_mask;
  logic       halt_mode;
  logic       ext_clock_pin;
  logic       overflow_irq;
  frt_count_t count_value;
  int         bad_count = 0;
  int         n_tests = 0;

  always #25 clk_sys = ~clk_sys;

  frt_top u_frt_top (
    .clk_sys(clk_sys), .arst_n(arst_n), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .global_irq_mask(global_irq_mask), .halt_mode(halt_mode),
    .ext_clock_pin(ext_clock_pin), .overflow_irq(overflow_irq), .count_value(count_value)
  );

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // all bench activity sits 1 ns after the rising edge, away from the sampling point
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask

  // a gap cycle after each strobe keeps a driver from assigning one signal twice a step
  task automatic wr(input frt_byte_t a, input frt_byte_t d);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    cyc(1);
    wr_stb  <= 1'b0;
    cyc(1);
  endtask

  task automatic rd(input frt_byte_t a, input frt_byte_t e);
    addr   <= a;
    rd_stb <= 1'b1;
    cyc(1);
    rd_stb <= 1'b0;
    chk("rd_data", {8'h00, e}, {8'h00, rd_data});
    cyc(1);
  endtask

  task automatic wait_chg(output int n);
    frt_count_t c;
    c = count_value;
    n = 0;
    while (count_value === c && n < 40) begin
      cyc(1);
      n++;
    end
    if (n >= 40) begin
      bad_count++;
      $display("[ERR] count_value exp change got %h", c);
      end_sim;
    end
  endtask

  initial begin
    #2000000;
    bad_count++;
    end_sim;
  end

  initial begin
    int n;
    clk_sys = 1'b0;
    arst_n = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    global_irq_mask = 1'b1;
    halt_mode = 1'b1;
    ext_clock_pin = 1'b0;
    cyc(3);
    arst_n <= 1'b1;
    cyc(1);
    chk("count_value", `FRT_CNT_RELOAD, count_value);
    rd(`FRT_ADDR_STATUS, 8'h00);
    rd(`FRT_ADDR_CTRL_ONE, `FRT_CTRL_RESET);
    rd(`FRT_ADDR_CTRL_TWO, `FRT_CTRL_RESET);
    rd(8'h07, `FRT_RD_NONE);
    done("reset");

    // eleven running cycles at divide by 2 carry fffc across ffff to 0001
    wr(`FRT_ADDR_CTRL_ONE, EN_B);
    rd(`FRT_ADDR_CNT_HI, 8'hff);
    halt_mode <= 1'b0;
    cyc(11);
    halt_mode <= 1'b1;
    cyc(3);
    chk("count_value", 16'h0001, count_value);
    chk("overflow_irq", 16'h0000, {15'h0000, overflow_irq});
    cyc(20);
    chk("count_value", 16'h0001, count_value);
    rd(`FRT_ADDR_CNT_HI, 8'h00);
    rd(`FRT_ADDR_CNT_LO, 8'hfc);
    rd(`FRT_ADDR_CNT_LO, 8'h01);
    rd(`FRT_ADDR_STATUS, OVF_B);
    rd(`FRT_ADDR_MIRROR_LO, 8'h01);
    rd(`FRT_ADDR_STATUS, OVF_B);
    global_irq_mask <= 1'b0;
    cyc(2);
    chk("overflow_irq", 16'h0001, {15'h0000, overflow_irq});
    wr(`FRT_ADDR_CTRL_ONE, 8'h00);
    chk("overflow_irq", 16'h0000, {15'h0000, overflow_irq});
    rd(`FRT_ADDR_CNT_LO, 8'h01);
    rd(`FRT_ADDR_STATUS, 8'h00);
    done("overflow");

    wr(`FRT_ADDR_MIRROR_LO, 8'h00);
    rd(`FRT_ADDR_MIRROR_HI, 8'hff);
    rd(`FRT_ADDR_MIRROR_LO, 8'hfc);
    done("reload");

    halt_mode <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      wr(`FRT_ADDR_CTRL_TWO, frt_byte_t'(i));
      wait_chg(n);
      wait_chg(n);
      chk("tick period", 16'h0002 << i, n[15:0]);
    end
    done("prescaler");

    // a train ending high holds one more rising than falling edge
    for (int e = 0; e < 2; e++) begin
      ext_clock_pin <= 1'b0;
      wr(`FRT_ADDR_CTRL_TWO, 8'h03 | (frt_byte_t'(e) << `FRT_CR2_EDGE_BIT));
      cyc(8);
      wr(`FRT_ADDR_CNT_LO, 8'h00);
      repeat (3) begin
        ext_clock_pin <= 1'b1;
        cyc(6);
        ext_clock_pin <= 1'b0;
        cyc(6);
      end
      ext_clock_pin <= 1'b1;
      cyc(8);
      chk("ext count", e ? 16'h0000 : 16'hffff, count_value);
    end
    done("external clock");
    end_sim;
  end
endmodule
